// file: rtl/img_params.svh
// Purpose: constants of the interrupt message generator
// Assumes: 32-bit apb data, byte offsets within a 256-byte window
// Notes:   definitions only
`ifndef IMG_PARAMS_SVH
`define IMG_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IMG_OFF_INT_MSI_CTRL 8'h00
`define IMG_OFF_GPIO_CTRL    8'h04
`define IMG_OFF_MSI_ADDR     8'h08
`define IMG_OFF_MSI_DATA     8'h0C
`define IMG_OFF_MSI_MAP      8'h10
`define IMG_OFF_MSI_MASK     8'h14
`define IMG_OFF_MSI_PEND     8'h18
`define IMG_OFF_REQ_ID       8'h1C
`define IMG_OFF_IRQ_STAT     8'h20
`define IMG_OFF_IRQ_MASK     8'h24
`define IMG_OFF_LINE_STAT    8'h28

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define IMG_RST_MSI_MAP  24'hFAC688
`define IMG_RST_MSI_MASK 8'hFF
`define IMG_RST_REQ_ID   16'h0000
`define IMG_MAP_W        3
`define IMG_EV_INTX      0
`define IMG_EV_MSI       1
`define IMG_EV_RETRY     2
`define IMG_EV_FWD       3

// ----------------------------------------------------------------
// message codes: assert a..d, deassert a..d
// ----------------------------------------------------------------
`define IMG_MSG_ASSERT_BASE   8'h20
`define IMG_MSG_DEASSERT_BASE 8'h24

`endif

// file: rtl/img_pkg.sv
// Purpose: types of the interrupt message generator
// Assumes: nothing
// Notes:   constants live in img_params.svh
`default_nettype none
package img_pkg;
  // ----------------------------------------------------------------
  // posted buffer entry
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IMG_KIND_MEMWR = 2'b00,
    IMG_KIND_MSG   = 2'b01
  } img_kind_t;

  typedef struct packed {
    img_kind_t   kind;     // memory write or message
    logic [7:0]  msg_code; // message code, zero for writes
    logic [15:0] req_id;   // requester id of the bridge
    logic [31:0] addr;     // write address
    logic [31:0] data;     // write data
  } img_entry_t;

  // forwarded write from the pci target side
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
  } img_fwd_t;

  typedef enum logic [2:0] {
    IMG_ST_IDLE     = 3'b000,
    IMG_ST_ASSERT   = 3'b001,
    IMG_ST_DEASSERT = 3'b010,
    IMG_ST_MSI      = 3'b011
  } img_state_t;
endpackage
`default_nettype wire

// file: rtl/img_top.sv
// Purpose: interrupt message generator feeding the upstream posted buffer
// Assumes: pins asynchronous; pci target signals on pclk
// Notes:   apb window of 256 bytes holds all registers
//
// Operation
// [R01] pin edges become assert or deassert messages
// [R02] forwarded msi writes pass as memory writes
// [R03] one posted buffer path for everything
// [R04] flags pending until buffer accepts message; code clears them on load into the output stage
// [R05] wait while pci posted transaction runs
// [R06] retry new posted attempts during load
// [R07] deassert only after assert on line
// [R08] round-robin among pending sources
// [R09] no queue; one pair per opportunity
// [R10] messages carry bridge requester id
// [R11] pin letter maps to same letter
// [R12] gpio falling edge triggers msi when enabled
// [R13] intx pins may send msi instead
// [R14] eight vectors, pin map, per-vector mask
// [R15] registers in a 256-byte window
// [R16] synchronise pins, detect both edges
// [R17] masked vector stays pending until unmasked
//
// The APB register port and the register offsets were left to the implementer.
`include "img_params.svh"
`default_nettype none
module img_top
  import img_pkg::*;
#(
  parameter int NVEC = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] intx_n,
  input wire logic [3:0] gpio,
  input wire logic pci_posted_busy,
  input wire logic pci_posted_req,
  output logic pci_retry,
  input wire logic fwd_valid,
  input wire img_fwd_t fwd,
  output logic fwd_ready,
  output logic pb_valid,
  output img_entry_t pb_entry,
  input wire logic pb_ready,
  output logic irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [3:0] intx_msi;        // intx line sends msi instead of messages
  logic [3:0] gpio_irq_en;     // gpio acts as interrupt input
  logic [31:0] msi_addr;       // msi target address
  logic [15:0] msi_data;       // msi base data, vector ored in
  logic [23:0] msi_map;        // 8 pins x 3 bits: intx 0..3, gpio 4..7
  logic [NVEC-1:0] msi_mask;   // per-vector mask
  logic [NVEC-1:0] msi_pend;   // vector waiting to be sent
  logic [15:0] req_id;         // bridge requester id
  logic [3:0] irq_stat;        // sticky events
  logic [3:0] irq_mask;        // event enables

  // ----------------------------------------------------------------
  // pin synchronisers and edge detectors
  // ----------------------------------------------------------------
  logic [7:0] pin_s1, pin_s2, pin_d;
  logic [7:0] pin_fall, pin_rise;

  // two flops, then a history flop for the edge detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 8'hFF;
      pin_s2 <= 8'hFF;
      pin_d <= 8'hFF;
    end else begin
      pin_s1 <= {gpio, intx_n};
      pin_s2 <= pin_s1;
      pin_d <= pin_s2;
    end
  end

  assign pin_fall = pin_d & ~pin_s2; // [R16]
  assign pin_rise = ~pin_d & pin_s2; // [R16]

  // ----------------------------------------------------------------
  // arbitration and sequencing
  // ----------------------------------------------------------------
  img_state_t state, next_state;
  logic [3:0] asrt_pend, dasrt_pend, line_up;
  logic [11:0] req;
  logic [3:0] rr_last, win, cur;
  logic out_free, load_int, load_fwd;
  logic [NVEC-1:0] msi_set, msi_clr;
  logic [3:0] set_a, set_d;
  logic [2:0] cur_vec;

  // round-robin: first requester after the last served one
  function automatic logic [3:0] rr_pick(input logic [11:0] r, input logic [3:0] last);
    logic [3:0] w;
    logic found;
    logic [4:0] idx;
    w = last;
    found = 1'b0;
    for (int k = 1; k <= 12; k++) begin
      idx = 5'(last) + 5'(k);
      if (idx >= 5'd12) begin
        idx = idx - 5'd12;
      end
      if (!found && r[idx[3:0]]) begin
        w = idx[3:0];
        found = 1'b1;
      end
    end
    return w;
  endfunction

  // a line asks while an assert is pending or a deassert may follow one
  assign req[3:0] = asrt_pend | (dasrt_pend & line_up); // [R07]
  assign req[11:4] = msi_pend & ~msi_mask; // [R17]
  assign win = rr_pick(req, rr_last); // [R08]
  assign cur_vec = 3'(cur - 4'd4);
  assign out_free = !pb_valid || pb_ready;
  assign load_int = out_free && (state != IMG_ST_IDLE);
  // forwarded writes use the same slot, only while no message is loading
  assign fwd_ready = out_free && (state == IMG_ST_IDLE); // [R03]
  assign load_fwd = fwd_valid && fwd_ready;
  // new posted attempts are retried while a message is being loaded
  assign pci_retry = (state != IMG_ST_IDLE); // [R06]

  // next state: start only when target side idle and no write forwarded
  always_comb begin
    next_state = state;
    case (state)
      IMG_ST_IDLE: begin
        if (|req && !pci_posted_busy && !fwd_valid) begin // [R05]
          if (win >= 4'd4) begin
            next_state = IMG_ST_MSI;
          end else if (asrt_pend[win[1:0]]) begin
            next_state = IMG_ST_ASSERT;
          end else begin
            next_state = IMG_ST_DEASSERT;
          end
        end
      end
      IMG_ST_ASSERT: begin
        if (load_int) begin
          // pair: deassert follows at once if pending, no more
          next_state = dasrt_pend[cur[1:0]] ? IMG_ST_DEASSERT : IMG_ST_IDLE; // [R09]
        end
      end
      IMG_ST_DEASSERT, IMG_ST_MSI: begin
        if (load_int) begin
          next_state = IMG_ST_IDLE;
        end
      end
      default: next_state = IMG_ST_IDLE;
    endcase
  end

  // state and the winner held through its loads
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IMG_ST_IDLE;
      cur <= 4'h0;
      rr_last <= 4'hB;
    end else begin
      state <= next_state;
      if (state == IMG_ST_IDLE && next_state != IMG_ST_IDLE) begin
        cur <= win;
        rr_last <= win; // [R08]
      end
    end
  end

  // ----------------------------------------------------------------
  // pending flags
  // ----------------------------------------------------------------
  // an edge in the same cycle as the clear keeps the flag set
  always_comb begin
    set_a = pin_fall[3:0] & ~intx_msi; // [R01]
    set_d = pin_rise[3:0] & ~intx_msi; // [R01]
    msi_set = '0;
    msi_clr = '0;
    for (int p = 0; p < 8; p++) begin
      if (pin_fall[p] && ((p < 4) ? intx_msi[p] : gpio_irq_en[p-4])) begin // [R12] [R13]
        msi_set[msi_map[p*3 +: 3]] = 1'b1; // [R14]
      end
    end
    if (state == IMG_ST_MSI && load_int) begin
      msi_clr[cur_vec] = 1'b1;
    end
  end

  // intx flags cleared only when the output stage takes the message
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      asrt_pend <= 4'h0;
      dasrt_pend <= 4'h0;
      line_up <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (set_a[i]) begin
          asrt_pend[i] <= 1'b1; // [R04]
        end else if (state == IMG_ST_ASSERT && load_int && cur == 4'(i)) begin
          asrt_pend[i] <= 1'b0;
        end
        if (set_d[i]) begin
          dasrt_pend[i] <= 1'b1; // [R04]
        end else if (state == IMG_ST_DEASSERT && load_int && cur == 4'(i)) begin
          dasrt_pend[i] <= 1'b0;
        end
        if (state == IMG_ST_ASSERT && load_int && cur == 4'(i)) begin
          line_up[i] <= 1'b1;
        end else if (state == IMG_ST_DEASSERT && load_int && cur == 4'(i)) begin
          line_up[i] <= 1'b0; // [R07]
        end
      end
    end
  end

  // vectors: set wins over clear, mask only holds them back
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msi_pend <= '0;
    end else begin
      msi_pend <= (msi_pend & ~msi_clr) | msi_set; // [R17]
    end
  end

  // ----------------------------------------------------------------
  // posted buffer output stage
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_valid <= 1'b0;
      pb_entry <= '0;
    end else if (out_free) begin
      pb_valid <= load_int || load_fwd;
      pb_entry.req_id <= req_id; // [R10]
      if (load_int && state == IMG_ST_MSI) begin
        pb_entry.kind <= IMG_KIND_MEMWR;
        pb_entry.msg_code <= 8'h00;
        pb_entry.addr <= msi_addr;
        pb_entry.data <= {16'h0000, msi_data | 16'(cur_vec)};
      end else if (load_int) begin
        pb_entry.kind <= IMG_KIND_MSG;
        // letter kept: line i gives code base+i
        pb_entry.msg_code <= ((state == IMG_ST_ASSERT) ? `IMG_MSG_ASSERT_BASE
                              : `IMG_MSG_DEASSERT_BASE) + 8'(cur[1:0]); // [R11]
        pb_entry.addr <= 32'h00000000;
        pb_entry.data <= 32'h00000000;
      end else if (load_fwd) begin
        pb_entry.kind <= IMG_KIND_MEMWR; // [R02]
        pb_entry.msg_code <= 8'h00;
        pb_entry.addr <= fwd.addr;
        pb_entry.data <= fwd.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_en, rd_en, hit;
  logic [3:0] ev;

  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign hit = (paddr <= `IMG_OFF_LINE_STAT) && (paddr[1:0] == 2'b00); // [R15]
  assign pslverr = psel && penable && !hit;

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intx_msi <= 4'h0;
      gpio_irq_en <= 4'h0;
      msi_addr <= 32'h00000000;
      msi_data <= 16'h0000;
      msi_map <= `IMG_RST_MSI_MAP;
      msi_mask <= NVEC'(`IMG_RST_MSI_MASK);
      req_id <= `IMG_RST_REQ_ID;
      irq_mask <= 4'h0;
    end else if (wr_en) begin
      if (paddr == `IMG_OFF_INT_MSI_CTRL) begin
        intx_msi <= pwdata[3:0]; // [R13]
      end else if (paddr == `IMG_OFF_GPIO_CTRL) begin
        gpio_irq_en <= pwdata[3:0]; // [R12]
      end else if (paddr == `IMG_OFF_MSI_ADDR) begin
        msi_addr <= pwdata;
      end else if (paddr == `IMG_OFF_MSI_DATA) begin
        msi_data <= pwdata[15:0];
      end else if (paddr == `IMG_OFF_MSI_MAP) begin
        msi_map <= pwdata[23:0];
      end else if (paddr == `IMG_OFF_MSI_MASK) begin
        msi_mask <= pwdata[NVEC-1:0]; // [R14]
      end else if (paddr == `IMG_OFF_REQ_ID) begin
        req_id <= pwdata[15:0];
      end else if (paddr == `IMG_OFF_IRQ_MASK) begin
        irq_mask <= pwdata[3:0];
      end
    end
  end

  // events: intx message, msi, retry, forwarded write
  always_comb begin
    ev = 4'h0;
    ev[`IMG_EV_INTX] = load_int && (state != IMG_ST_MSI);
    ev[`IMG_EV_MSI] = load_int && (state == IMG_ST_MSI);
    ev[`IMG_EV_RETRY] = pci_posted_req && pci_retry;
    ev[`IMG_EV_FWD] = load_fwd;
  end

  // sticky status, write one to clear, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= (irq_stat & ~((wr_en && paddr == `IMG_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0)) | ev;
    end
  end

  assign irq = |(irq_stat & irq_mask);

  // read mux, registered data is the register itself
  always_comb begin
    prdata = 32'h00000000;
    if (rd_en) begin
      if (paddr == `IMG_OFF_INT_MSI_CTRL) begin
        prdata = {28'h0000000, intx_msi};
      end else if (paddr == `IMG_OFF_GPIO_CTRL) begin
        prdata = {28'h0000000, gpio_irq_en};
      end else if (paddr == `IMG_OFF_MSI_ADDR) begin
        prdata = msi_addr;
      end else if (paddr == `IMG_OFF_MSI_DATA) begin
        prdata = {16'h0000, msi_data};
      end else if (paddr == `IMG_OFF_MSI_MAP) begin
        prdata = {8'h00, msi_map};
      end else if (paddr == `IMG_OFF_MSI_MASK) begin
        prdata = 32'(msi_mask);
      end else if (paddr == `IMG_OFF_MSI_PEND) begin
        prdata = 32'(msi_pend);
      end else if (paddr == `IMG_OFF_REQ_ID) begin
        prdata = {16'h0000, req_id};
      end else if (paddr == `IMG_OFF_IRQ_STAT) begin
        prdata = {28'h0000000, irq_stat};
      end else if (paddr == `IMG_OFF_IRQ_MASK) begin
        prdata = {28'h0000000, irq_mask};
      end else if (paddr == `IMG_OFF_LINE_STAT) begin
        prdata = {20'h00000, line_up, dasrt_pend, asrt_pend};
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_retry_on_load: assert property (pci_posted_req && state != IMG_ST_IDLE |-> pci_retry) // [R06]
    else $error("posted attempt not retried during load");
  a_busy_stalls: assert property (state == IMG_ST_IDLE && pci_posted_busy |=> state == IMG_ST_IDLE) // [R05]
    else $error("message load started during posted transaction");
  a_deassert_order: assert property (state == IMG_ST_DEASSERT |-> line_up[cur[1:0]]) // [R07]
    else $error("deassert without prior assert");
  a_flag_held: assert property (asrt_pend[0] && !(state == IMG_ST_ASSERT && load_int && cur == 4'h0)
    |=> asrt_pend[0]) // [R04]
    else $error("assert flag lost before acceptance");
  a_letter_kept: assert property (state == IMG_ST_ASSERT && load_int
    |=> pb_valid && pb_entry.msg_code == `IMG_MSG_ASSERT_BASE + 8'($past(cur[1:0]))) // [R11]
    else $error("assert message letter remapped");
  a_own_id: assert property (pb_valid && pb_entry.kind == IMG_KIND_MSG |-> pb_entry.req_id == req_id) // [R10]
    else $error("message without bridge requester id");
  a_mask_blocks: assert property (state == IMG_ST_MSI |-> !msi_mask[cur_vec]) // [R14]
    else $error("masked vector sent");
  a_pair_follows: assert property (state == IMG_ST_ASSERT && load_int && dasrt_pend[cur[1:0]]
    |=> state == IMG_ST_DEASSERT ##1 state == IMG_ST_DEASSERT || state == IMG_ST_IDLE) // [R09]
    else $error("deassert did not follow its assert");
  a_edge_flag: assert property (pin_fall[0] && !intx_msi[0] |=> asrt_pend[0]) // [R16]
    else $error("falling edge did not set assert flag");
  a_gpio_msi: assert property (pin_fall[5] && gpio_irq_en[1] |=> msi_pend[$past(msi_map[17:15])]) // [R12]
    else $error("gpio edge did not raise msi");
  a_fwd_path: assert property (load_fwd |=> pb_valid && pb_entry.kind == IMG_KIND_MEMWR) // [R02]
    else $error("forwarded write not loaded");

  c_assert_pair: cover property (state == IMG_ST_ASSERT ##1 state == IMG_ST_DEASSERT);
  c_msi_sent: cover property (state == IMG_ST_MSI && load_int);
  c_retry_seen: cover property (pci_posted_req && pci_retry);
  c_fwd_write: cover property (load_fwd);

endmodule
`default_nettype wire

// file: testbench/img_pb_sink.sv
// Purpose: upstream posted buffer sink standing in for the link to the root
// Assumes: an entry is taken at an edge with pb_valid and pb_ready high
// Notes:   slow mode opens the buffer one cycle in four
`default_nettype none
module img_pb_sink (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  output logic pb_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase; // free-running slot counter
  // ----------------------------------------------------------------
  // ready pattern
  // ----------------------------------------------------------------
  // a stalled buffer forces the generator to hold its entry and flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 2'h0;
      pb_ready <= 1'h0; // not accepting until reset is over
    end else begin
      phase <= phase + 2'h1;
      pb_ready <= !slow || (phase == 2'h3);
    end
  end
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Purpose: self-checking bench of the interrupt message generator
// Assumes: posted buffer sink model in img_pb_sink.sv
// Notes:   expected entries come from a queue model fed by the stimulus
`include "img_params.svh"
`default_nettype none
module tb_top
  import img_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, pci_retry, fwd_ready, pb_valid, pb_ready, irq;
  logic [3:0] intx_n = 4'hF, gpio = 4'hF;
  logic pci_posted_busy = 1'h0, pci_posted_req = 1'h0, fwd_valid = 1'h0, slow = 1'h0;
  img_fwd_t fwd = '0, fv;
  img_entry_t pb_entry;
  img_entry_t exp_q[$]; // entries the buffer must see, in order
  logic [15:0] m_rid = 16'h0, md;
  logic [31:0] ma, rd;
  logic err, seen_retry;
  int n_mismatch = 0, total_checks = 0, cycles = 0, k;

  always #2 pclk = ~pclk; // 250 MHz

  img_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .intx_n(intx_n), .gpio(gpio), .pci_posted_busy(pci_posted_busy), .pci_posted_req(pci_posted_req),
    .pci_retry(pci_retry), .fwd_valid(fwd_valid), .fwd(fwd), .fwd_ready(fwd_ready),
    .pb_valid(pb_valid), .pb_entry(pb_entry), .pb_ready(pb_ready), .irq(irq));
  img_pb_sink sink (.pclk(pclk), .presetn(presetn), .slow(slow), .pb_ready(pb_ready));

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // messages carry no address or data, so only header fields count
  task automatic cmp_entry(input img_entry_t e, input img_entry_t g);
    if (e.kind == IMG_KIND_MSG) begin
      g.addr = '0;
      g.data = '0;
    end
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD posted entry exp %h got %h", e, g);
    end
  endtask
  task automatic push(input img_kind_t kd, input logic [7:0] c, input logic [31:0] a, input logic [31:0] d);
    exp_q.push_back('{kind: kd, msg_code: c, req_id: m_rid, addr: a, data: d});
  endtask
  // ----------------------------------------------------------------
  // apb master: setup, access until pready, then release
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
                     output logic e);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    logic x;
    apb(1'h0, a, 32'h0, r, x);
    cmp_word(nm, e, r);
  endtask
  // wait for the model queue to empty, then a quiet spell catches extras
  task automatic drain();
    int c;
    c = 0;
    while (exp_q.size() != 0 && c < 300) begin
      @(posedge pclk);
      c++;
    end
    cmp_word("entries left", 32'h0, 32'(exp_q.size()));
    repeat (8) @(posedge pclk);
  endtask

  // ----------------------------------------------------------------
  // buffer monitor, retry watch and timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cycles++;
    if (pci_retry === 1'h1) seen_retry = 1'h1;
    if (cycles == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
    if (presetn === 1'h1 && pb_valid === 1'h1 && pb_ready === 1'h1) begin
      if (exp_q.size() == 0) cmp_entry('0, pb_entry);
      else cmp_entry(exp_q.pop_front(), pb_entry);
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h631fdac2));
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    rdchk(`IMG_OFF_MSI_MAP, 32'h00FAC688, "msi map");
    rdchk(`IMG_OFF_MSI_MASK, 32'h000000FF, "msi mask");
    rdchk(`IMG_OFF_REQ_ID, 32'h0, "req id");
    apb(1'h0, 8'hFC, 32'h0, rd, err);
    cmp_word("unmapped err", 32'h1, {31'h0, err});
    cmp_word("unmapped data", 32'h0, rd);
    m_rid = 16'($urandom);
    wr(`IMG_OFF_REQ_ID, {16'h0, m_rid});
    // every line asserts then deasserts with its own letter; sink slow on c and d
    for (k = 0; k < 4; k++) begin
      slow <= (k > 1);
      push(IMG_KIND_MSG, 8'(`IMG_MSG_ASSERT_BASE + k), 32'h0, 32'h0);
      push(IMG_KIND_MSG, 8'(`IMG_MSG_DEASSERT_BASE + k), 32'h0, 32'h0);
      @(posedge pclk);
      intx_n[k] <= 1'h0;
      repeat (30) @(posedge pclk);
      intx_n[k] <= 1'h1;
      drain();
    end
    // an edge during a target posted write waits; new attempts are retried
    slow <= 1'h0;
    pci_posted_busy <= 1'h1;
    pci_posted_req <= 1'h1;
    @(posedge pclk);
    intx_n[1] <= 1'h0;
    repeat (20) @(posedge pclk);
    rdchk(`IMG_OFF_LINE_STAT, 32'h2, "line status");
    // the pin rises while still stalled: both flags wait and then leave as one pair
    intx_n[1] <= 1'h1;
    repeat (8) @(posedge pclk);
    rdchk(`IMG_OFF_LINE_STAT, 32'h22, "line both");
    seen_retry = 1'h0;
    push(IMG_KIND_MSG, 8'(`IMG_MSG_ASSERT_BASE + 1), 32'h0, 32'h0);
    push(IMG_KIND_MSG, 8'(`IMG_MSG_DEASSERT_BASE + 1), 32'h0, 32'h0);
    pci_posted_busy <= 1'h0;
    drain();
    cmp_word("retry seen", 32'h1, {31'h0, seen_retry});
    pci_posted_req <= 1'h0;
    push(IMG_KIND_MSG, 8'(`IMG_MSG_ASSERT_BASE + 1), 32'h0, 32'h0);
    push(IMG_KIND_MSG, 8'(`IMG_MSG_DEASSERT_BASE + 1), 32'h0, 32'h0);
    intx_n[1] <= 1'h0;
    repeat (30) @(posedge pclk);
    intx_n[1] <= 1'h1;
    drain();
    // lines a and c together: after b was served, c goes first
    push(IMG_KIND_MSG, 8'(`IMG_MSG_ASSERT_BASE + 2), 32'h0, 32'h0);
    push(IMG_KIND_MSG, 8'(`IMG_MSG_ASSERT_BASE + 0), 32'h0, 32'h0);
    @(posedge pclk);
    intx_n <= 4'hA;
    drain();
    rdchk(`IMG_OFF_LINE_STAT, 32'h500, "lines up");
    push(IMG_KIND_MSG, 8'(`IMG_MSG_DEASSERT_BASE + 2), 32'h0, 32'h0);
    push(IMG_KIND_MSG, 8'(`IMG_MSG_DEASSERT_BASE + 0), 32'h0, 32'h0);
    intx_n <= 4'hF;
    drain();
    // back-to-back forwarded writes against a stalling buffer
    slow <= 1'h1;
    for (k = 0; k < 4; k++) begin
      fv = {$urandom, $urandom};
      push(IMG_KIND_MEMWR, 8'h00, fv.addr, fv.data);
      fwd <= fv;
      fwd_valid <= 1'h1;
      do begin
        @(posedge pclk);
      end while (fwd_ready !== 1'h1);
    end
    fwd_valid <= 1'h0;
    drain();
    // line a in msi mode on vector 0; its rising edge is ignored
    slow <= 1'h0;
    ma = $urandom & 32'hFFFFFFFC;
    md = 16'($urandom) & 16'hFFF8;
    wr(`IMG_OFF_INT_MSI_CTRL, 32'h1);
    wr(`IMG_OFF_MSI_ADDR, ma);
    wr(`IMG_OFF_MSI_DATA, {16'h0, md});
    wr(`IMG_OFF_MSI_MASK, 32'hFE);
    push(IMG_KIND_MEMWR, 8'h00, ma, {16'h0, md});
    intx_n[0] <= 1'h0;
    drain();
    intx_n[0] <= 1'h1;
    // gpio 1 remapped onto masked vector 6, held until unmasked
    wr(`IMG_OFF_MSI_MAP, 32'h00FB4688);
    wr(`IMG_OFF_GPIO_CTRL, 32'h2);
    gpio[1] <= 1'h0;
    repeat (20) @(posedge pclk);
    rdchk(`IMG_OFF_MSI_PEND, 32'h40, "msi pending");
    push(IMG_KIND_MEMWR, 8'h00, ma, {16'h0, md | 16'h6});
    wr(`IMG_OFF_MSI_MASK, 32'hBE);
    drain();
    // event status, mask and write-one-to-clear
    wr(`IMG_OFF_IRQ_MASK, 32'h0);
    rdchk(`IMG_OFF_IRQ_STAT, 32'hF, "irq status");
    @(posedge pclk);
    cmp_word("irq masked", 32'h0, {31'h0, irq});
    wr(`IMG_OFF_IRQ_MASK, 32'h2);
    @(posedge pclk);
    cmp_word("irq raised", 32'h1, {31'h0, irq});
    wr(`IMG_OFF_IRQ_STAT, 32'h2);
    @(posedge pclk);
    cmp_word("irq cleared", 32'h0, {31'h0, irq});
    rdchk(`IMG_OFF_IRQ_STAT, 32'hD, "irq left");
    report_and_stop();
  end
endmodule
`default_nettype wire
